// ---- include/flag_ctrl_pkg.sv ----
// Constants and types for the converter status, flag and enable control block.
// Assumes a single 50 MHz clock and an I2C master outside driving SCL and SDA.
package flag_ctrl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 50000000;
    localparam int unsigned UV_CYCLES       = 8;

    // ------------------------------------------------------------
    // I2C address and register indices
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_UPPER       = 4'h2;
    localparam logic [7:0] REG_CONTROL      = 8'h00;
    localparam logic [7:0] REG_DELAY_SOFT   = 8'h01;
    localparam logic [7:0] REG_OFFSET       = 8'h02;
    localparam logic [7:0] REG_MODE_FREQ    = 8'h03;
    localparam logic [7:0] REG_STATUS       = 8'h04;
    localparam logic [7:0] REG_FLAGS        = 8'h05;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int unsigned CTL_SOFT_EN_BIT = 0;
    localparam int unsigned CTL_CLEAR_BIT   = 1;
    localparam int unsigned FLG_UV_BIT      = 0;
    localparam int unsigned FLG_OV_BIT      = 1;
    localparam int unsigned FLG_OT_BIT      = 2;
    localparam int unsigned FLG_CURRENT_LIMIT_FLAG_BIT    = 3;
    localparam int unsigned FLG_DIP_BIT     = 4;
    localparam int unsigned FLG_DNS_BIT     = 5;
    localparam int unsigned ST_DCM_BIT      = 0;
    localparam int unsigned ST_GOOD_BIT     = 1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CONTROL_RST      = 8'h01;
    localparam logic [7:0] DELAY_SOFT_RST   = 8'h00;
    localparam logic [7:0] OFFSET_RST       = 8'h00;
    // Frequency code 0 is 250 kHz, code 3 is 1 MHz, in steps of 250 kHz
    localparam logic [7:0] MODE_FREQ_RST    = 8'h00;
    localparam logic [1:0] FREQ_CODE_MAX    = 2'h3;

    typedef enum logic [2:0] {
        I2C_IDLE,
        I2C_ADDR,
        I2C_ACK_ADDR,
        I2C_WRITE,
        I2C_ACK_WRITE,
        I2C_READ,
        I2C_ACK_READ
    } i2c_state_t;

endpackage

// ---- logic/i2c_reg_slave.sv ----
// I2C slave with an 8-bit register pointer; reads a byte array, writes by strobe.
// Assumes SCL and SDA already pass through two flip-flops in the caller.
module i2c_reg_slave (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    input  wire logic [2:0] addr_pins_i,
    input  wire logic [7:0] rd_data_i,
    output logic [7:0]      reg_ptr_o,
    output logic            wr_stb_o,
    output logic [7:0]      wr_data_o
);

    typedef struct packed {
        logic                     scl;
        logic                     sda;
        flag_ctrl_pkg::i2c_state_t st;
        logic [7:0]               sh;
        logic [2:0]               cnt;
        logic                     full;
        logic                     rw;
        logic                     ptr_set;
        logic [7:0]               ptr;
        logic                     oe;
        logic                     stb;
        logic [7:0]               wdata;
    } state_t;

    state_t q;
    state_t d;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl_rise = scl_i & ~q.scl;
    assign scl_fall = ~scl_i & q.scl;
    assign start_c  = scl_i & q.scl & q.sda & ~sda_i;
    assign stop_c   = scl_i & q.scl & ~q.sda & sda_i;

    // ------------------------------------------------------------
    // Bus protocol
    // ------------------------------------------------------------
    always_comb begin
        d     = q;
        d.scl = scl_i;
        d.sda = sda_i;
        d.stb = 1'b0;
        if (start_c) begin
            d.st  = flag_ctrl_pkg::I2C_ADDR;
            d.cnt = 3'h0;
            d.full = 1'b0;
            d.oe  = 1'b0;
        end else if (stop_c) begin
            d.st = flag_ctrl_pkg::I2C_IDLE;
            d.oe = 1'b0;
        end else begin
            case (q.st)
                flag_ctrl_pkg::I2C_IDLE: begin
                    d.oe = 1'b0;
                end
                flag_ctrl_pkg::I2C_ADDR, flag_ctrl_pkg::I2C_WRITE: begin
                    if (scl_rise) begin
                        d.sh  = {q.sh[6:0], sda_i};
                        d.cnt  = q.cnt + 3'h1;
                        d.full = (q.cnt == 3'h7);
                    end
                    if (scl_fall && q.full) begin
                        if (q.st == flag_ctrl_pkg::I2C_ADDR) begin
                            if (q.sh[7:1] == {flag_ctrl_pkg::ADDR_UPPER, addr_pins_i}) begin
                                d.rw      = q.sh[0];
                                d.ptr_set = 1'b0;
                                d.oe      = 1'b1;
                                d.st      = flag_ctrl_pkg::I2C_ACK_ADDR;
                            end else begin
                                d.st = flag_ctrl_pkg::I2C_IDLE;
                            end
                        end else begin
                            if (!q.ptr_set) begin
                                d.ptr     = q.sh;
                                d.ptr_set = 1'b1;
                            end else begin
                                d.stb   = 1'b1;
                                d.wdata = q.sh;
                            end
                            d.oe = 1'b1;
                            d.st = flag_ctrl_pkg::I2C_ACK_WRITE;
                        end
                    end
                end
                flag_ctrl_pkg::I2C_ACK_ADDR, flag_ctrl_pkg::I2C_ACK_WRITE: begin
                    if (scl_fall) begin
                        d.cnt = 3'h0;
                        if (q.st == flag_ctrl_pkg::I2C_ACK_ADDR && q.rw) begin
                            d.sh = rd_data_i;
                            d.oe = ~rd_data_i[7];
                            d.st = flag_ctrl_pkg::I2C_READ;
                        end else begin
                            d.oe = 1'b0;
                            d.st = flag_ctrl_pkg::I2C_WRITE;
                        end
                    end
                    if (q.stb) begin
                        d.ptr = q.ptr + 8'h01;
                    end
                end
                flag_ctrl_pkg::I2C_READ: begin
                    if (scl_fall) begin
                        d.cnt = q.cnt + 3'h1;
                        if (q.cnt == 3'h7) begin
                            d.oe  = 1'b0;
                            d.ptr = q.ptr + 8'h01;
                            d.st  = flag_ctrl_pkg::I2C_ACK_READ;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.oe = ~q.sh[6];
                        end
                    end
                end
                flag_ctrl_pkg::I2C_ACK_READ: begin
                    if (scl_rise) begin
                        d.rw = ~sda_i;
                    end
                    if (scl_fall) begin
                        if (q.rw) begin
                            d.sh  = rd_data_i;
                            d.oe  = ~rd_data_i[7];
                            d.cnt = 3'h0;
                            d.st  = flag_ctrl_pkg::I2C_READ;
                        end else begin
                            d.st = flag_ctrl_pkg::I2C_IDLE;
                        end
                    end
                end
                default: begin
                    d.st = flag_ctrl_pkg::I2C_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{scl: 1'b1, sda: 1'b1, st: flag_ctrl_pkg::I2C_IDLE, default: '0};
        end else begin
            q <= d;
        end
    end

    assign sda_oe_o  = q.oe;
    assign reg_ptr_o = q.ptr;
    assign wr_stb_o  = q.stb;
    assign wr_data_o = q.wdata;

endmodule

// ---- logic/status_flag_enable_control.sv ----
// Status, sticky flag and enable control of a step-down converter, reached by I2C.
// Assumes fault conditions arrive as levels from analogue comparators outside this clock.
//
// Behaviour
// - Each status bit reads one exactly while its condition is present; output good also needs the converter running.
// - Each flag bit sets on its condition and stays set until a clearing event.
// - Discontinuous mode and output good are live status; the six faults are sticky.
// - Flags clear on input supply cycling, enable pin cycling, or the clear command.
// - The converter runs only with supplies present and the enable pin high.
// - Enable pin low turns the converter off and clears all flags.
// - With the pin high, soft enable zero stops the converter and keeps the flags.
// - Soft enable back to one with the pin high restarts the converter.
// - I2C reads and writes on/off, delay, soft-start, offset, margin, mode, frequency.
// - I2C reads all status and all flag bits.
// - Three address pins supply the three low bits of the slave address.
// - The frequency setting spans 250 kHz to 1 MHz.
// - The serial port is a standard I2C slave.
// - Did-not-start sets if feedback is under 90 percent after soft-start and good delay.
// - Clearing the overvoltage flag by the clear command works only once feedback is below 120 percent.
// - After undervoltage latch-off, restart needs the pin or soft enable low then high.
module status_flag_enable_control (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       enable_pin_i,
    input  wire logic       supplies_ok_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe_o,
    input  wire logic       address_select_pin_low_i,
    input  wire logic       address_select_pin_mid_i,
    input  wire logic       address_select_pin_high_i,
    input  wire logic       dcm_cond_i,
    input  wire logic       feedback_node_good_i,
    input  wire logic       feedback_node_over_i,
    input  wire logic       uv_latch_cond_i,
    input  wire logic       thermal_cond_i,
    input  wire logic       current_limit_cond_i,
    input  wire logic       input_dip_cond_i,
    input  wire logic       start_window_done_i,
    output logic            converter_run_o,
    output logic [7:0]      delay_soft_o,
    output logic [7:0]      offset_margin_o,
    output logic [7:0]      mode_freq_o,
    output logic            output_good_status_o,
    output logic            low_output_latch_flag_o,
    output logic            overvoltage_flag_o,
    output logic            thermal_trip_flag_o,
    output logic            current_limit_flag_o,
    output logic            input_dip_flag_o,
    output logic            start_failure_flag_o
);

    localparam int unsigned NSYNC = 14;

    typedef struct packed {
        logic [NSYNC-1:0] s1;
        logic [NSYNC-1:0] s2;
        logic             pin_prev;
        logic             sup_prev;
        logic             converter_soft_enable;
        logic [7:0]       delay_soft;
        logic [7:0]       offset;
        logic [7:0]       mode_freq;
        logic [5:0]       flags;
        logic             uv_latched;
        logic             run;
    } state_t;

    state_t q;
    state_t d;

    logic [7:0] reg_ptr;
    logic       wr_stb;
    logic [7:0] wr_data;
    logic [7:0] rd_data;
    logic [NSYNC-1:0] raw;

    // Synchronised copies, and s_win taken straight from start_window_done_i
    logic s_en;
    logic s_sup;
    logic s_scl;
    logic s_sda;
    logic [2:0] s_addr;
    logic s_dcm;
    logic s_good;
    logic s_over;
    logic s_uv;
    logic s_ot;
    logic s_current_limit_flag;
    logic s_dip;
    logic s_win;

    logic       pin_low;
    logic       sup_loss;
    logic       flag_clear_command;
    logic [5:0] cond;
    logic [5:0] clr_mask;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign raw = {enable_pin_i, supplies_ok_i, scl_i, sda_i,
                  address_select_pin_high_i, address_select_pin_mid_i,
                  address_select_pin_low_i, dcm_cond_i, feedback_node_good_i,
                  feedback_node_over_i, uv_latch_cond_i, thermal_cond_i,
                  current_limit_cond_i, input_dip_cond_i};
    assign {s_en, s_sup, s_scl, s_sda, s_addr, s_dcm, s_good,
            s_over, s_uv, s_ot, s_current_limit_flag, s_dip} = q.s2;
    assign s_win = start_window_done_i;

    // ------------------------------------------------------------
    // I2C port
    // ------------------------------------------------------------
    i2c_reg_slave u_i2c (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .scl_i       (s_scl),
        .sda_i       (s_sda),
        .sda_oe_o    (sda_oe_o),
        .addr_pins_i (s_addr),
        .rd_data_i   (rd_data),
        .reg_ptr_o   (reg_ptr),
        .wr_stb_o    (wr_stb),
        .wr_data_o   (wr_data)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (reg_ptr)
            flag_ctrl_pkg::REG_CONTROL:    rd_data = {7'h00, q.converter_soft_enable};
            flag_ctrl_pkg::REG_DELAY_SOFT: rd_data = q.delay_soft;
            flag_ctrl_pkg::REG_OFFSET:     rd_data = q.offset;
            flag_ctrl_pkg::REG_MODE_FREQ:  rd_data = q.mode_freq;
            flag_ctrl_pkg::REG_STATUS:     rd_data = {6'h00, q.run & s_good, s_dcm};
            flag_ctrl_pkg::REG_FLAGS:      rd_data = {2'h0, q.flags};
            default:                       rd_data = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Control and flags
    // ------------------------------------------------------------
    assign pin_low            = ~s_en;
    assign sup_loss           = ~s_sup;
    assign flag_clear_command = wr_stb && reg_ptr == flag_ctrl_pkg::REG_CONTROL
                                && wr_data[flag_ctrl_pkg::CTL_CLEAR_BIT];

    always_comb begin
        cond = 6'h00;
        cond[flag_ctrl_pkg::FLG_UV_BIT]   = q.run & s_uv;
        cond[flag_ctrl_pkg::FLG_OV_BIT]   = s_over;
        cond[flag_ctrl_pkg::FLG_OT_BIT]   = s_ot;
        cond[flag_ctrl_pkg::FLG_CURRENT_LIMIT_FLAG_BIT] = s_current_limit_flag;
        cond[flag_ctrl_pkg::FLG_DIP_BIT]  = s_dip;
        cond[flag_ctrl_pkg::FLG_DNS_BIT]  = q.run & s_win & ~s_good;
        clr_mask = 6'h00;
        if (pin_low || sup_loss) begin
            clr_mask = 6'h3F;
            cond     = 6'h00;
        end else if (flag_clear_command) begin
            clr_mask = 6'h3F;
            clr_mask[flag_ctrl_pkg::FLG_OV_BIT] = ~s_over;
        end
    end

    always_comb begin
        d          = q;
        d.s1       = raw;
        d.s2       = q.s1;
        d.pin_prev = s_en;
        d.sup_prev = s_sup;
        if (wr_stb) begin
            case (reg_ptr)
                flag_ctrl_pkg::REG_CONTROL: begin
                    d.converter_soft_enable = wr_data[flag_ctrl_pkg::CTL_SOFT_EN_BIT];
                end
                flag_ctrl_pkg::REG_DELAY_SOFT: d.delay_soft = wr_data;
                flag_ctrl_pkg::REG_OFFSET:     d.offset = wr_data;
                flag_ctrl_pkg::REG_MODE_FREQ: begin
                    d.mode_freq = wr_data;
                    if (wr_data[1:0] > flag_ctrl_pkg::FREQ_CODE_MAX) begin
                        d.mode_freq[1:0] = flag_ctrl_pkg::FREQ_CODE_MAX;
                    end
                end
                default: d.mode_freq = q.mode_freq;
            endcase
        end
        d.flags = (q.flags & ~clr_mask) | cond;
        // Undervoltage latch released only by an enable low phase
        if (pin_low || !d.converter_soft_enable) begin
            d.uv_latched = 1'b0;
        end else if (cond[flag_ctrl_pkg::FLG_UV_BIT]) begin
            d.uv_latched = 1'b1;
        end
        d.run = s_en & s_sup & d.converter_soft_enable & ~d.uv_latched
                & ~s_ot;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '{converter_soft_enable: flag_ctrl_pkg::CONTROL_RST[0],
                   delay_soft: flag_ctrl_pkg::DELAY_SOFT_RST,
                   offset: flag_ctrl_pkg::OFFSET_RST,
                   mode_freq: flag_ctrl_pkg::MODE_FREQ_RST,
                   default: '0};
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign converter_run_o         = q.run;
    assign delay_soft_o            = q.delay_soft;
    assign offset_margin_o         = q.offset;
    assign mode_freq_o             = q.mode_freq;
    assign output_good_status_o    = q.run & s_good;
    assign low_output_latch_flag_o = q.flags[flag_ctrl_pkg::FLG_UV_BIT];
    assign overvoltage_flag_o      = q.flags[flag_ctrl_pkg::FLG_OV_BIT];
    assign thermal_trip_flag_o     = q.flags[flag_ctrl_pkg::FLG_OT_BIT];
    assign current_limit_flag_o    = q.flags[flag_ctrl_pkg::FLG_CURRENT_LIMIT_FLAG_BIT];
    assign input_dip_flag_o        = q.flags[flag_ctrl_pkg::FLG_DIP_BIT];
    assign start_failure_flag_o    = q.flags[flag_ctrl_pkg::FLG_DNS_BIT];

endmodule

// ---- bench/flag_ctrl_sva.sv ----
// Checker of run, flag, status and SDA behaviour of the flag control block.
// Assumes it is bound to status_flag_enable_control and sees its ports only.
module flag_ctrl_sva (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic enable_pin_i,
    input wire logic supplies_ok_i,
    input wire logic scl_i,
    input wire logic sda_oe_o,
    input wire logic feedback_node_good_i,
    input wire logic thermal_cond_i,
    input wire logic current_limit_cond_i,
    input wire logic converter_run_o,
    input wire logic output_good_status_o,
    input wire logic low_output_latch_flag_o,
    input wire logic overvoltage_flag_o,
    input wire logic thermal_trip_flag_o,
    input wire logic current_limit_flag_o,
    input wire logic input_dip_flag_o,
    input wire logic start_failure_flag_o
);
    timeunit 1ns;
    timeprecision 100ps;
    wire logic [5:0] flags = {start_failure_flag_o, input_dip_flag_o, current_limit_flag_o,
                              thermal_trip_flag_o, overvoltage_flag_o, low_output_latch_flag_o};
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    a_pin_stops_run: assert property (!enable_pin_i [*4] |-> !converter_run_o)
        else $error("run while enable pin low");
    a_supply_stops_run: assert property (!supplies_ok_i [*4] |-> !converter_run_o)
        else $error("run while supplies absent");
    a_pin_low_clears: assert property (!enable_pin_i [*4] |-> flags == 6'h00)
        else $error("flag kept while enable pin low");
    a_supply_clears: assert property (!supplies_ok_i [*4] |-> flags == 6'h00)
        else $error("flag kept while supplies absent");
    a_current_limit_flag_sets_flag: assert property ((current_limit_cond_i && enable_pin_i && supplies_ok_i) [*5]
        |-> current_limit_flag_o)
        else $error("current limit flag not set");
    a_ot_sets_flag: assert property ((thermal_cond_i && enable_pin_i && supplies_ok_i) [*5]
        |-> thermal_trip_flag_o)
        else $error("thermal flag not set");
    a_flag_stays_set: assert property ((enable_pin_i && supplies_ok_i && scl_i) [*5]
        |=> (($past(flags) & ~flags) == 6'h00))
        else $error("flag dropped without clearing event");
    a_good_follows: assert property (feedback_node_good_i [*3] ##0 converter_run_o
        |-> output_good_status_o)
        else $error("output good missing while good and running");
    a_good_drops: assert property (!feedback_node_good_i [*3] |-> !output_good_status_o)
        else $error("output good while condition absent");
    a_good_needs_run: assert property (output_good_status_o |-> converter_run_o)
        else $error("output good while stopped");
    a_idle_bus_quiet: assert property (scl_i [*6] |-> !sda_oe_o)
        else $error("SDA pulled while bus idle");
endmodule

bind status_flag_enable_control flag_ctrl_sva u_sva (.*);

// ---- bench/i2c_host_model.sv ----
// Host I2C master model driving SCL and SDA of the flag control block.
// Assumes the bench builds the pulled-up SDA wire; SCL period 160 ns.
module i2c_host_model (
    output logic      scl_o,
    output logic      sda_o,
    input  wire logic sda_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // Bus conditions and byte transfer
    // ------------------------------------------------------------
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic start();
        #40 sda_o = 1'b1;
        #40 scl_o = 1'b1;
        #40 sda_o = 1'b0;
        #40 scl_o = 1'b0;
    endtask
    task automatic stop();
        #40 sda_o = 1'b0;
        #40 scl_o = 1'b1;
        #40 sda_o = 1'b1;
        #80;
    endtask
    // Eight bits MSB first, then the acknowledge bit; 1 releases SDA
    task automatic byte_io(input logic [7:0] d, input logic ack_in, output logic [7:0] r,
                           output logic ack_out);
        logic b;
        for (int i = 0; i < 9; i++) begin
            #40 sda_o = (i < 8) ? d[7 - i] : ack_in;
            #40 scl_o = 1'b1;
            #40 b = sda_i;
            #40 scl_o = 1'b0;
            if (i < 8) r[7 - i] = b;
            else ack_out = b;
        end
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench of the flag control block driven through an I2C host model.
// Assumes the package, design, checker and host model are compiled first.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk = 1'b0;
    logic        rst_n;
    logic        en;
    logic        sup;
    logic        run;
    logic        oe;
    logic        scl;
    logic        hsda;
    logic [7:0]  c;
    logic [2:0]  apins;
    logic [6:0]  dev;
    logic [31:0] rnd;
    logic [7:0]  v;
    logic [7:0]  q;
    logic [7:0]  setv[3];
    logic        k;
    integer      seed;
    int          fail_count;
    int          comparisons;
    logic [7:0]  exp_q[$];
    logic [7:0]  got_q[$];
    event        seen_ev;
    wire logic   sda = hsda & ~oe;
    always #10 mclk = ~mclk;
    status_flag_enable_control u_dut (
        .mclk_i(mclk), .rst_n_i(rst_n), .enable_pin_i(en), .supplies_ok_i(sup),
        .scl_i(scl), .sda_i(sda), .sda_oe_o(oe), .address_select_pin_low_i(apins[0]),
        .address_select_pin_mid_i(apins[1]), .address_select_pin_high_i(apins[2]),
        .dcm_cond_i(c[0]), .feedback_node_good_i(c[1]), .feedback_node_over_i(c[2]),
        .uv_latch_cond_i(c[3]), .thermal_cond_i(c[4]), .current_limit_cond_i(c[5]),
        .input_dip_cond_i(c[6]), .start_window_done_i(c[7]), .converter_run_o(run),
        .delay_soft_o(setv[0]), .offset_margin_o(setv[1]), .mode_freq_o(setv[2]),
        .output_good_status_o(),
        .low_output_latch_flag_o(), .overvoltage_flag_o(), .thermal_trip_flag_o(),
        .current_limit_flag_o(), .input_dip_flag_o(), .start_failure_flag_o()
    );
    i2c_host_model u_host (.scl_o(scl), .sda_o(hsda), .sda_i(sda));
    // ------------------------------------------------------------
    // Checking and transfer tasks
    // ------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] e);
        comparisons++;
        if (got !== e) begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h expected=%h", $time, got, e);
        end
    endtask
    always @(seen_ev) while (got_q.size() > 0) check(got_q.pop_front(), exp_q.pop_front());
    task automatic note(input logic [7:0] e);
        exp_q.push_back(e);
    endtask
    task automatic show(input logic [7:0] g);
        got_q.push_back(g);
        ->seen_ev;
    endtask
    task automatic complete_run();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] ra, input logic [7:0] d, input logic rd,
                        input logic [7:0] e);
        u_host.start();
        u_host.byte_io({dev, 1'b0}, 1'b1, q, k);
        note(8'h00);
        show({7'h00, k});
        u_host.byte_io(ra, 1'b1, q, k);
        if (rd) begin
            u_host.start();
            u_host.byte_io({dev, 1'b1}, 1'b1, q, k);
            u_host.byte_io(8'hFF, 1'b1, q, k);
            note(e);
            show(q);
        end else begin
            u_host.byte_io(d, 1'b1, q, k);
        end
        u_host.stop();
    endtask
    task automatic run_is(input logic e);
        for (int i = 0; i < 20 && run !== e; i++) @(negedge mclk);
        if (run !== e) begin
            fail_count++;
            complete_run();
        end
        note({7'h00, e});
        show({7'h00, run});
    endtask
    task automatic hold(input logic [7:0] cv);
        c = cv;
        repeat (10) @(negedge mclk);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hEC7D;
        fail_count = 0;
        comparisons = 0;
        c = 8'h00;
        en = 1'b1;
        sup = 1'b1;
        rst_n = 1'b0;
        rnd = $random(seed);
        apins = rnd[2:0];
        dev = {flag_ctrl_pkg::ADDR_UPPER, apins};
        repeat (12) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        repeat (4) @(negedge mclk);
        for (int i = 0; i < 7; i++) xfer(8'(i), 8'h00, 1'b1, (i == 0) ? 8'h01 : 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 7; i++) begin
            rnd = $random(seed);
            v = (i < 3) ? rnd[7:0] : 8'(i - 3);
            xfer((i < 3) ? 8'(i + 1) : 8'h03, v, 1'b0, 8'h00);
            xfer((i < 3) ? 8'(i + 1) : 8'h03, 8'h00, 1'b1, v);
            note(v);
            show(setv[(i < 3) ? i : 2]);
        end
        $display("test settings done");
        u_host.start();
        u_host.byte_io({dev ^ 7'h01, 1'b0}, 1'b1, q, k);
        u_host.stop();
        note(8'h01);
        show({7'h00, k});
        $display("test address done");
        hold(8'h01);
        xfer(8'h04, 8'h00, 1'b1, 8'h01);
        hold(8'h02);
        xfer(8'h04, 8'h00, 1'b1, 8'h02);
        hold(8'h00);
        xfer(8'h04, 8'h00, 1'b1, 8'h00);
        $display("test live_status done");
        hold(8'h74);
        hold(8'h00);
        xfer(8'h05, 8'h00, 1'b1, 8'h1E);
        run_is(1'b1);
        hold(8'h24);
        xfer(8'h00, 8'h03, 1'b0, 8'h00);
        xfer(8'h05, 8'h00, 1'b1, 8'h0A);
        hold(8'h00);
        xfer(8'h00, 8'h03, 1'b0, 8'h00);
        xfer(8'h05, 8'h00, 1'b1, 8'h00);
        xfer(8'h00, 8'h00, 1'b1, 8'h01);
        $display("test clear done");
        hold(8'h10);
        hold(8'h00);
        run_is(1'b1);
        xfer(8'h00, 8'h00, 1'b0, 8'h00);
        run_is(1'b0);
        xfer(8'h05, 8'h00, 1'b1, 8'h04);
        xfer(8'h00, 8'h01, 1'b0, 8'h00);
        run_is(1'b1);
        hold(8'h80);
        xfer(8'h05, 8'h00, 1'b1, 8'h24);
        run_is(1'b1);
        hold(8'h00);
        $display("test soft_enable done");
        en = 1'b0;
        run_is(1'b0);
        xfer(8'h05, 8'h00, 1'b1, 8'h00);
        en = 1'b1;
        run_is(1'b1);
        hold(8'h40);
        hold(8'h00);
        sup = 1'b0;
        run_is(1'b0);
        repeat (10) @(negedge mclk);
        sup = 1'b1;
        xfer(8'h05, 8'h00, 1'b1, 8'h00);
        run_is(1'b1);
        $display("test pin_supply done");
        hold(8'h08);
        hold(8'h00);
        repeat (30) @(negedge mclk);
        run_is(1'b0);
        xfer(8'h05, 8'h00, 1'b1, 8'h01);
        xfer(8'h00, 8'h00, 1'b0, 8'h00);
        xfer(8'h00, 8'h01, 1'b0, 8'h00);
        run_is(1'b1);
        $display("test latch_off done");
        #100;
        complete_run();
    end
    initial begin
        #2000000;
        fail_count++;
        complete_run();
    end
endmodule
